// >>> rtl/sms_defines.svh
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH

// bus clock period in ns
`define SMS_CLK_PERIOD_NS  40
// serial byte width and half-clock edges per transfer
`define SMS_DATA_W         8
`define SMS_LAST_BIT       4'h7
`define SMS_LAST_EDGE      5'h10
// master baud divisors, selected by {rate_select_hi, rate_select_lo}
`define SMS_DIV_RATE0      8'h02
`define SMS_DIV_RATE1      8'h08
`define SMS_DIV_RATE2      8'h20
`define SMS_DIV_RATE3      8'h80
// receive buffer depth
`define SMS_BUF_DEPTH      2
`define SMS_BUF_FULL       2'h2

`endif

// >>> rtl/sms_pkg.sv
`include "sms_defines.svh"

package sms_pkg;
    // transfer state of the shift engine
    typedef enum logic {
        SMS_IDLE,
        SMS_XFER
    } sms_state_t;
    typedef logic [`SMS_DATA_W-1:0] sms_byte_t;
endpackage : sms_pkg

// >>> rtl/sms_buf_if.sv
`timescale 1ns/1ns
`include "sms_defines.svh"

// ready/valid path between shift engine and receive buffer
interface sms_buf_if;
    logic                   in_valid;
    logic                   in_ready;
    logic [`SMS_DATA_W-1:0] in_data;
    logic                   out_valid;
    logic                   out_ready;
    logic [`SMS_DATA_W-1:0] out_data;
    modport push  (output in_valid, output in_data, input in_ready);
    modport pop   (input out_valid, input out_data, output out_ready);
    modport store (input in_valid, input in_data, input out_ready,
                   output in_ready, output out_valid, output out_data);
endinterface : sms_buf_if

// >>> rtl/sms_buf.sv
`timescale 1ns/1ns
`include "sms_defines.svh"

module sms_buf (
    input wire logic i_mclk,
    input wire logic i_resetn,
    sms_buf_if.store bi
);
    logic [`SMS_DATA_W-1:0] mem_ff [`SMS_BUF_DEPTH];
    logic                   wr_ptr_ff;
    logic                   rd_ptr_ff;
    logic [1:0]             cnt_ff;
    logic                   push;
    logic                   pop;

    // handshake terms from the fill count
    assign bi.in_ready  = (cnt_ff != `SMS_BUF_FULL);
    assign bi.out_valid = (cnt_ff != 2'h0);
    assign bi.out_data  = mem_ff[rd_ptr_ff];
    assign push         = bi.in_valid & bi.in_ready;
    assign pop          = bi.out_valid & bi.out_ready;

    // one storage word per entry
    generate
        for (genvar g = 0; g < `SMS_BUF_DEPTH; g++) begin : g_ent
            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    mem_ff[g] <= 8'h00;
                end else if (push && (wr_ptr_ff == 1'(g))) begin
                    mem_ff[g] <= bi.in_data;
                end
            end
        end
    endgenerate

    // pointers and fill count
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            cnt_ff    <= 2'h0;
        end else begin
            if (push) wr_ptr_ff <= ~wr_ptr_ff;
            if (pop) rd_ptr_ff <= ~rd_ptr_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : sms_buf

// >>> rtl/sms_core.sv
`timescale 1ns/1ns
`include "sms_defines.svh"

module sms_core import sms_pkg::*; (
    input  wire logic       i_mclk,
    input  wire logic       i_resetn,
    input  wire logic       i_port_enable,
    input  wire logic       i_master_select,
    input  wire logic       i_clock_polarity,
    input  wire logic       i_clock_phase,
    input  wire logic       i_rate_select_hi,
    input  wire logic       i_rate_select_lo,
    input  wire logic       i_mode_fault_enable,
    input  wire logic       i_data_wr,
    input  wire logic [7:0] i_data_wdata,
    input  wire logic       i_status_rd,
    input  wire logic       i_data_rd,
    input  wire logic       i_mode_fault_clr,
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_miso,
    input  wire logic       i_ss_n,
    output logic            o_sck,
    output logic            o_sck_oe_n,
    output logic            o_mosi,
    output logic            o_mosi_oe_n,
    output logic            o_miso,
    output logic            o_miso_oe_n,
    output logic [7:0]      o_rx_data,
    output logic            o_tx_empty_flag,
    output logic            o_rx_full_flag,
    output logic            o_overflow_flag,
    output logic            o_mode_fault_flag,
    output logic            o_busy
);
    sms_state_t state_ff;
    sms_byte_t  hold_ff;
    sms_byte_t  tx_sh_ff;
    sms_byte_t  rx_sh_ff;
    logic       hold_full_ff;
    logic       tx_empty_ff;
    logic       sh_pend_ff;
    logic [6:0] div_cnt_ff;
    logic [4:0] edge_cnt_ff;
    logic [2:0] bit_idx_ff;
    logic [3:0] smp_cnt_ff;
    logic       sck_lvl_ff;
    logic       sck_prev_ff;
    logic       ss_prev_ff;
    logic       armed_ff;
    logic       ovf_ff;
    logic       mf_ff;
    logic [7:0] div_sel;
    logic [6:0] half_sel;
    logic [4:0] nedge;
    logic       active;
    logic       is_master;
    logic       tick;
    logic       m_edge;
    logic       s_edge;
    logic       s_start;
    logic       go;
    logic       edge_ev;
    logic       samp;
    logic       shft;
    logic       last_samp;
    logic       done;
    logic       abort;
    logic       load;
    logic       rx_in;
    logic       out_bit;
    logic       mf_set;
    logic       ovf_set;
    logic       rd_clear;

    sms_buf_if rxq ();

    sms_buf u_buf (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .bi       (rxq)
    );

    // master mode fault turns the port off like a cleared enable
    assign is_master = i_master_select;
    assign active    = i_port_enable & ~(mf_ff & is_master);

    // master baud divider, slaves never use it
    always_comb begin
        unique case ({i_rate_select_hi, i_rate_select_lo})
            2'h0: div_sel = `SMS_DIV_RATE0;
            2'h1: div_sel = `SMS_DIV_RATE1;
            2'h2: div_sel = `SMS_DIV_RATE2;
            2'h3: div_sel = `SMS_DIV_RATE3;
        endcase
    end
    assign half_sel = div_sel[7:1];
    assign tick     = active & is_master & (div_cnt_ff == half_sel - 7'h01);

    // free-running divider while enabled as master
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_cnt_ff <= 7'h00;
        end else if (!(active && is_master) || tick) begin
            div_cnt_ff <= 7'h00;
        end else begin
            div_cnt_ff <= div_cnt_ff + 7'h01;
        end
    end

    // edge and start detection for both roles
    assign m_edge  = (state_ff == SMS_XFER) & is_master & tick;
    assign s_edge  = active & ~is_master & ~i_ss_n & (i_sck != sck_prev_ff);
    assign s_start = active & ~is_master & (state_ff == SMS_IDLE) &
                     (i_clock_phase ? s_edge : (ss_prev_ff & ~i_ss_n));
    assign go      = is_master ? ((state_ff == SMS_IDLE) & sh_pend_ff & tick)
                               : s_start;
    assign edge_ev = m_edge | (s_edge & ((state_ff == SMS_XFER) | s_start));
    assign nedge   = (s_start ? 5'h00 : edge_cnt_ff) + 5'h01;
    // phase zero samples odd edges; phase one drives on odd, samples even
    assign samp    = edge_ev & (i_clock_phase ? ~nedge[0] : nedge[0]);
    assign shft    = edge_ev & (i_clock_phase ? (nedge[0] & (nedge != 5'h01))
                                              : ~nedge[0]);
    assign last_samp = samp & (smp_cnt_ff == `SMS_LAST_BIT);
    assign done    = is_master ? (m_edge & (nedge == `SMS_LAST_EDGE)) : last_samp;
    assign abort   = (state_ff == SMS_XFER) & (~active | (~is_master & i_ss_n));
    assign load    = hold_full_ff & (state_ff == SMS_IDLE) & ~go;
    assign rx_in   = is_master ? i_miso : i_mosi;
    assign out_bit = tx_sh_ff[3'h7 - bit_idx_ff];

    // transfer state
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= SMS_IDLE;
        end else if (abort || done) begin
            state_ff <= SMS_IDLE;
        end else if (go) begin
            state_ff <= SMS_XFER;
        end
    end

    // edge, bit and sample counters
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            edge_cnt_ff <= 5'h00;
            bit_idx_ff  <= 3'h0;
            smp_cnt_ff  <= 4'h0;
        end else if (go && !edge_ev) begin
            edge_cnt_ff <= 5'h00;
            bit_idx_ff  <= 3'h0;
            smp_cnt_ff  <= 4'h0;
        end else if (edge_ev) begin
            edge_cnt_ff <= nedge;
            if (s_start) begin
                bit_idx_ff <= 3'h0;
                smp_cnt_ff <= 4'h0;
            end else begin
                if (shft) bit_idx_ff <= bit_idx_ff + 3'h1;
                if (samp) smp_cnt_ff <= smp_cnt_ff + 4'h1;
            end
        end
    end

    // receive shift register, msb first
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_sh_ff <= 8'h00;
        end else if (samp) begin
            rx_sh_ff <= {rx_sh_ff[6:0], rx_in};
        end
    end

    // master clock level, toggled on every generated edge
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sck_lvl_ff <= 1'b0;
        end else if (state_ff == SMS_IDLE) begin
            sck_lvl_ff <= i_clock_polarity;
        end else if (m_edge) begin
            sck_lvl_ff <= ~sck_lvl_ff;
        end
    end

    // pin history for edge detection
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sck_prev_ff <= 1'b0;
            ss_prev_ff  <= 1'b1;
        end else begin
            sck_prev_ff <= i_sck;
            ss_prev_ff  <= i_ss_n;
        end
    end

    // transmit holding register and shift register
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_ff      <= 8'h00;
            hold_full_ff <= 1'b0;
            tx_sh_ff     <= 8'h00;
            sh_pend_ff   <= 1'b0;
        end else begin
            if (i_data_wr) begin
                hold_ff      <= i_data_wdata;
                hold_full_ff <= 1'b1;
            end else if (load || (abort && is_master)) begin
                hold_full_ff <= 1'b0;
            end
            if (load) begin
                tx_sh_ff   <= hold_ff;
                sh_pend_ff <= 1'b1;
            end else if (go || !active) begin
                sh_pend_ff <= 1'b0;
            end
        end
    end

    // transmit empty: a write clears it, a move into the shifter sets it
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_empty_ff <= 1'b1;
        end else if (i_data_wr) begin
            tx_empty_ff <= 1'b0;
        end else if (load || (abort && is_master)) begin
            tx_empty_ff <= 1'b1;
        end
    end

    // receive buffer: push completed bytes, pop on the read sequence
    assign ovf_set       = last_samp & (~rxq.in_ready | ovf_ff);
    assign rxq.in_valid  = last_samp & ~ovf_ff;
    assign rxq.in_data   = {rx_sh_ff[6:0], rx_in};
    assign rd_clear      = i_data_rd & armed_ff;
    assign rxq.out_ready = rd_clear;

    // status read seeing a flag arms the clearing data read
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            armed_ff <= 1'b0;
        end else if (i_status_rd && (rxq.out_valid || ovf_ff)) begin
            armed_ff <= 1'b1;
        end else if (i_data_rd) begin
            armed_ff <= 1'b0;
        end
    end

    // overflow flag, set wins over the clearing read only while the flag is clear
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            ovf_ff <= 1'b0;
        end else if (ovf_set && !ovf_ff) begin
            ovf_ff <= 1'b1;
        end else if (rd_clear) begin
            ovf_ff <= 1'b0;
        end
    end

    // mode fault flag, set wins over clear
    assign mf_set = i_mode_fault_enable & i_port_enable &
                    (is_master ? ~i_ss_n
                               : ((state_ff == SMS_XFER) & i_ss_n & ~ss_prev_ff));
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            mf_ff <= 1'b0;
        end else if (mf_set) begin
            mf_ff <= 1'b1;
        end else if (i_mode_fault_clr) begin
            mf_ff <= 1'b0;
        end
    end

    // pin drivers; enables are low while driving
    assign o_sck       = is_master ? sck_lvl_ff : i_clock_polarity;
    assign o_sck_oe_n  = ~(active & is_master);
    assign o_mosi      = out_bit;
    assign o_mosi_oe_n = ~(active & is_master);
    assign o_miso      = out_bit;
    assign o_miso_oe_n = ~(active & ~is_master & ~i_ss_n);

    // status outputs
    assign o_rx_data         = rxq.out_data;
    assign o_rx_full_flag    = rxq.out_valid;
    assign o_tx_empty_flag   = tx_empty_ff;
    assign o_overflow_flag   = ovf_ff;
    assign o_mode_fault_flag = mf_ff;
    assign o_busy            = (state_ff == SMS_XFER);

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    a_write_clears_te: assert property (
        i_data_wr |=> !o_tx_empty_flag) else $error("tx empty not cleared by write");
    a_load_moves_byte: assert property (
        load && !i_data_wr |=> o_tx_empty_flag && tx_sh_ff == $past(hold_ff))
        else $error("idle shifter did not take the written byte");
    a_master_start: assert property (
        $rose(o_busy) && is_master |-> $past(sh_pend_ff) && $past(tick))
        else $error("master started without a pending byte");
    a_rx_post: assert property (
        last_samp && !o_rx_full_flag && !ovf_ff |=> o_rx_full_flag &&
        o_rx_data == $past(rxq.in_data)) else $error("received byte not posted");
    a_rx_clear_seq: assert property (
        $fell(o_rx_full_flag) |-> $past(i_data_rd) && $past(armed_ff))
        else $error("rx full cleared without read sequence");
    a_miso_select: assert property (
        !o_miso_oe_n |-> !i_ss_n && !i_master_select) else $error("unselected slave drives");
    a_sck_idle_lvl: assert property (
        !o_busy && i_master_select |=> o_busy || o_sck == $past(i_clock_polarity))
        else $error("idle clock level wrong");
    a_rate1_period: assert property (
        o_busy && is_master && {i_rate_select_hi, i_rate_select_lo} == 2'h1 &&
        $changed(o_sck) |=> $stable(o_sck)[*3]) else $error("half period not four cycles");
    a_cpha0_start: assert property (
        s_start && !i_clock_phase |=> o_busy && bit_idx_ff == 3'h0 && !o_miso_oe_n)
        else $error("slave msb not presented at select fall");
    a_shifter_frozen: assert property (
        o_busy && $past(o_busy) |-> $stable(tx_sh_ff)) else $error("shifter reloaded mid-transfer");
    a_overflow_set: assert property (
        last_samp && !rxq.in_ready && !rd_clear |=> o_overflow_flag && $stable(o_rx_data))
        else $error("overrun not flagged");
    a_master_fault: assert property (
        i_mode_fault_enable && i_port_enable && is_master && !i_ss_n
        |=> o_mode_fault_flag ##1 !o_busy) else $error("master mode fault missed");
    a_eight_samples: assert property (
        done |-> smp_cnt_ff + {3'h0, samp} == `SMS_LAST_BIT + 4'h1)
        else $error("byte not eight bits");

    c_master_xfer: cover property (is_master && done);
    c_slave_cpha0: cover property (!is_master && !i_clock_phase && done);
    c_slave_cpha1: cover property (!is_master && i_clock_phase && done);
    c_overflow:    cover property ($rose(o_overflow_flag));
endmodule : sms_core

// >>> testbench/sms_partner.sv
`timescale 1ns/1ns
// far-end slave model, clocked by the serial clock pin itself
module sms_partner (
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    input  wire logic       i_pol,
    input  wire logic       i_pha,
    input  wire logic [7:0] i_tx,
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    logic [7:0] sh = 8'h00;
    logic [2:0] cnt = 3'h0;
    initial o_miso = 1'b0;
    initial o_rx = 8'h00;
    // phase zero: msb out on select fall; a released line shows the inverse
    always @(i_ss_n) begin
        cnt = 3'h0;
        if (!i_ss_n && !i_pha) begin
            sh = i_tx;
            o_miso = sh[7];
        end else if (i_ss_n) begin
            o_miso = ~o_miso;
        end
    end
    // sampling edge takes mosi, the other edge moves the next bit out
    always @(i_sck) begin
        if (!i_ss_n) begin
            if ((i_sck != i_pol) ^ i_pha) begin
                o_rx = {o_rx[6:0], i_mosi};
                cnt = cnt + 3'h1;
            end else if (i_pha) begin
                if (cnt == 3'h0) sh = i_tx;
                o_miso = sh[7];
                sh = {sh[6:0], 1'b0};
            end else begin
                sh = {sh[6:0], 1'b0};
                o_miso = sh[7];
            end
        end
    end
endmodule : sms_partner

// >>> testbench/test_spi_master_slave_shift_core.sv
`timescale 1ns/1ns
module test_spi_master_slave_shift_core;
    logic       clk = 1'b0, resetn = 1'b0, port_en = 1'b0, master = 1'b0;
    logic       pol = 1'b0, pha = 1'b0, mf_en = 1'b0, mf_clr = 1'b0;
    logic       wr = 1'b0, st_rd = 1'b0, dt_rd = 1'b0, prev_busy = 1'b0;
    logic       tb_sck = 1'b0, tb_mosi = 1'b0, ss_n = 1'b1, part_ss_n = 1'b1;
    logic [1:0] rate = 2'h0;
    logic [7:0] wdata = 8'h00, part_tx = 8'h00, rx_data, part_rx;
    logic       sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, part_miso;
    logic       tx_empty, rx_full, ovf, mfault, busy;
    logic [7:0] exp_q[$];
    int         error_cnt = 0, total_checks = 0, cycles = 0;
    // pin levels resolved from the enables of both parties
    wire        sck_w  = sck_oe_n ? tb_sck : sck_o;
    wire        mosi_w = mosi_oe_n ? tb_mosi : mosi_o;
    wire        miso_w = miso_oe_n ? part_miso : miso_o;

    sms_core sms_core_inst (
        .i_mclk(clk), .i_resetn(resetn), .i_port_enable(port_en),
        .i_master_select(master), .i_clock_polarity(pol), .i_clock_phase(pha),
        .i_rate_select_hi(rate[1]), .i_rate_select_lo(rate[0]),
        .i_mode_fault_enable(mf_en), .i_data_wr(wr), .i_data_wdata(wdata),
        .i_status_rd(st_rd), .i_data_rd(dt_rd), .i_mode_fault_clr(mf_clr),
        .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .i_ss_n(ss_n),
        .o_sck(sck_o), .o_sck_oe_n(sck_oe_n), .o_mosi(mosi_o),
        .o_mosi_oe_n(mosi_oe_n), .o_miso(miso_o), .o_miso_oe_n(miso_oe_n),
        .o_rx_data(rx_data), .o_tx_empty_flag(tx_empty), .o_rx_full_flag(rx_full),
        .o_overflow_flag(ovf), .o_mode_fault_flag(mfault), .o_busy(busy)
    );
    sms_partner sms_partner_inst (
        .i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(part_ss_n), .i_pol(pol),
        .i_pha(pha), .i_tx(part_tx), .o_miso(part_miso), .o_rx(part_rx)
    );

    // bus clock
    initial begin
        forever #20 clk = ~clk;
    end

    // watchdog, and far-end byte compared against the oldest note
    always @(posedge clk) begin
        cycles <= cycles + 1;
        prev_busy <= busy;
        if (cycles == 40000) begin
            error_cnt++;
            $display("MISMATCH %0t timeout", $time);
            stop_test();
        end
        if (prev_busy && !busy && master && exp_q.size() > 0)
            chk({8'h00, part_rx}, {8'h00, exp_q.pop_front()}, "far end rx");
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp, input string s);
        chk({15'h0, got}, {15'h0, exp}, s);
    endtask : chk1
    task automatic end_test(input string s);
        $display("test %s done, %0d checks", s, total_checks);
    endtask : end_test
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    // port off while the format changes, clock parked at idle first
    task automatic cfg(input logic m, input logic p, input logic h, input logic [1:0] r);
        port_en <= 1'b0;
        tick(1);
        master <= m;
        pol <= p;
        pha <= h;
        rate <= r;
        tb_sck <= p;
        tick(1);
        port_en <= 1'b1;
        tick(2);
    endtask : cfg
    task automatic put(input logic [7:0] d);
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask : put
    // status read then data read
    task automatic rd_clear();
        st_rd <= 1'b1;
        tick(1);
        st_rd <= 1'b0;
        dt_rd <= 1'b1;
        tick(1);
        dt_rd <= 1'b0;
        tick(2);
    endtask : rd_clear
    // one master transfer, busy length measured against the divider
    task automatic mxfer(input logic [7:0] d, input logic [7:0] p);
        int n;
        part_tx <= p;
        part_ss_n <= 1'b0;
        exp_q.push_back(d);
        tick(1);
        put(d);
        chk1(tx_empty, 1'b0, "tx empty cleared");
        tick(1);
        chk1(tx_empty, 1'b1, "byte moved to shifter");
        n = 0;
        while (busy !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        n = 0;
        while (busy === 1'b1) begin
            tick(1);
            n++;
        end
        chk(16'(n), 16'(16 << (2 * rate)), "busy cycles");
        part_ss_n <= 1'b1;
        tick(1);
        chk1(rx_full, 1'b1, "rx full at end");
        chk({8'h00, rx_data}, {8'h00, p}, "rx byte");
    endtask : mxfer

    initial begin
        logic [7:0] b, p, got;
        int         n;
        void'($urandom(32'h278d));
        tick(16);
        resetn <= 1'b1;
        tick(2);
        chk1(tx_empty, 1'b1, "reset tx empty");
        chk1(rx_full | ovf | mfault | busy, 1'b0, "reset flags");
        chk1(miso_oe_n, 1'b1, "idle slave output");
        end_test("reset");
        // every format once, every rate once
        for (int k = 0; k < 4; k++) begin
            cfg(1'b1, k[0], k[1], 2'(3 - k));
            chk1(sck_oe_n, 1'b0, "master drives clock");
            b = 8'($urandom);
            p = 8'($urandom);
            mxfer(b, p);
            dt_rd <= 1'b1;
            tick(1);
            dt_rd <= 1'b0;
            tick(2);
            chk1(rx_full, 1'b1, "data read alone");
            rd_clear();
            chk1(rx_full, 1'b0, "rx full cleared");
        end
        end_test("master formats");
        // three queued bytes, select kept low, no reads between
        cfg(1'b1, 1'b0, 1'b1, 2'h0);
        part_tx <= 8'($urandom);
        part_ss_n <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            n = 0;
            while (tx_empty !== 1'b1 && n < 100) begin
                tick(1);
                n++;
            end
            put(b);
        end
        n = 0;
        while ((busy === 1'b1 || exp_q.size() > 0) && n < 2000) begin
            tick(1);
            n++;
        end
        part_ss_n <= 1'b1;
        tick(2);
        chk(16'(exp_q.size()), 16'h0000, "queued bytes sent");
        chk1(ovf, 1'b1, "overflow on third byte");
        chk({8'h00, rx_data}, {8'h00, part_tx}, "oldest byte kept");
        rd_clear();
        chk1(ovf, 1'b0, "overflow cleared");
        chk1(rx_full, 1'b1, "second byte remains");
        rd_clear();
        chk1(rx_full, 1'b0, "buffer drained");
        end_test("queue and overflow");
        // bench as master, both phases, rate bits random
        for (int k = 0; k < 2; k++) begin
            cfg(1'b0, 1'($urandom), k[0], 2'($urandom));
            chk1(sck_oe_n, 1'b1, "slave takes clock");
            // second pass writes nothing, so the shifter resends its byte
            if (k == 0) b = 8'($urandom);
            p = 8'($urandom);
            if (k == 0) put(b);
            ss_n <= 1'b0;
            tb_mosi <= p[7];
            tick(4);
            chk1(miso_oe_n, 1'b0, "selected slave drives");
            for (int i = 7; i >= 0; i--) begin
                if (!pha) got[i] = miso_w;
                tb_sck <= ~pol;
                if (pha) tb_mosi <= p[i];
                tick(4);
                if (pha) got[i] = miso_w;
                tb_sck <= pol;
                if (!pha && i > 0) tb_mosi <= p[i-1];
                tick(4);
            end
            ss_n <= 1'b1;
            tb_mosi <= ~tb_mosi;
            tick(3);
            chk({8'h00, got}, {8'h00, b}, "slave sent msb first");
            chk1(rx_full, 1'b1, "slave rx full");
            chk({8'h00, rx_data}, {8'h00, p}, "slave rx byte");
            chk1(miso_oe_n, 1'b1, "released slave");
            rd_clear();
        end
        end_test("slave phases");
        // master with select pulled low
        cfg(1'b1, 1'b0, 1'b0, 2'h0);
        mf_en <= 1'b1;
        ss_n <= 1'b0;
        tick(3);
        chk1(mfault, 1'b1, "mode fault set");
        ss_n <= 1'b1;
        mf_clr <= 1'b1;
        tick(1);
        mf_clr <= 1'b0;
        mf_en <= 1'b0;
        tick(2);
        chk1(mfault, 1'b0, "mode fault cleared");
        end_test("mode fault");
        // slave deselected in mid-transfer
        cfg(1'b0, 1'b0, 1'b0, 2'h0);
        mf_en <= 1'b1;
        ss_n <= 1'b0;
        tick(4);
        chk1(busy, 1'b1, "slave started on select fall");
        ss_n <= 1'b1;
        tick(3);
        chk1(mfault, 1'b1, "slave mode fault");
        chk1(busy, 1'b0, "slave transfer aborted");
        mf_clr <= 1'b1;
        mf_en <= 1'b0;
        tick(1);
        mf_clr <= 1'b0;
        tick(2);
        chk1(mfault, 1'b0, "slave mode fault cleared");
        end_test("slave fault");
        stop_test();
    end
endmodule : test_spi_master_slave_shift_core
